// *** verilog/tdm_audio_host.sv ***
// Host end: makes the bit clock, frame sync and audio data, and
// captures the returned current-sense slot. Software drives it over
// AXI4-Lite. Assumes the AXI master is in the clk domain.
`timescale 1ns/1ps
module tdm_audio_host #(
	parameter int HALF_CYC = tdm_pkg::HOST_HALF_CYC // Bit clock half
) (
	input wire logic clk, // System clock, 200 MHz
	input wire logic rst_n, // Synchronous reset, active low
	tdm_link_if.host link, // Serial link pins
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [7:0] awaddr, // Write address
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte enables
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	output logic [1:0] bresp, // Write response
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	input wire logic [7:0] araddr, // Read address
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp // Read response
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] div; // Half period divider
		logic bclk; // Bit clock pin
		logic [9:0] hp; // Launch position in frame
		logic fsync; // Frame sync pin
		logic sdata; // Data pin
		logic [31:0] rxsh; // Sense bits
		logic [31:0] rx_sense; // Last whole sense word
		logic [15:0] frames; // Frames sent
		logic en; // Link enable
		logic [1:0] fmt; // Format
		logic [3:0] rslot; // Sense slot to capture
		logic [31:0] txw; // Transmit word
		logic aw_hold; // Write address held
		logic [7:0] wa; // Held write address
		logic w_hold; // Write data held
		logic [31:0] wd; // Held write data
		logic [3:0] ws; // Held byte enables
		logic awready; // AXI outputs
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} host_t;
	host_t s; // Current state
	host_t next_s; // Next state

	logic sense_lvl; // Settled sense pin
	logic [9:0] fbits; // Bit clocks per frame
	logic [9:0] mask; // Position wrap mask
	logic [9:0] hp_n; // Next launch position
	logic [9:0] q_tx; // Bit index of launched bit
	logic [9:0] q_rx; // Bit index of sampled bit
	logic [31:0] txword; // Word of the current slot

	// ==========================================================
	// Sense pin synchroniser
	edge_sync #(.W(1)) sense_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(link.sense),
		.level(sense_lvl),
		.rise(),
		.fall()
	);

	// Frame length follows the format written by software
	assign fbits = tdm_pkg::I2S_FRAME_BITS << s.fmt;
	assign mask = fbits - 10'h001;
	assign hp_n = (s.hp + 10'h001) & mask;
	// Data trails frame sync by one bit clock
	assign q_tx = (hp_n - 10'h001) & mask;
	assign q_rx = (s.hp - 10'h001) & mask;
	// Slot index folded in so each slot is distinguishable
	assign txword = s.txw ^ {28'h0000000, q_tx[8:5]};

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_s = s;
		// Link engine
		if (!s.en)
		begin
			next_s.div = 8'h00;
			next_s.bclk = 1'b0;
			next_s.hp = tdm_pkg::POS_MAX;
			next_s.fsync = 1'b0;
			next_s.sdata = 1'b0;
		end
		else if (s.div == 8'(HALF_CYC - 1))
		begin
			next_s.div = 8'h00;
			next_s.bclk = ~s.bclk;
			if (s.bclk)
			begin
				// Falling edge: launch the next position
				next_s.hp = hp_n;
				next_s.fsync = (s.fmt == tdm_pkg::FMT_I2S) ?
					(hp_n < tdm_pkg::I2S_HALF_BITS) :
					(hp_n == 10'h000);
				next_s.sdata = txword[~q_tx[4:0]];
				if (hp_n == 10'h000)
					next_s.frames = s.frames + 16'h0001;
			end
			else if (q_rx[8:5] == s.rslot)
			begin
				// Rising edge: sample the sense slot
				next_s.rxsh = {s.rxsh[30:0], sense_lvl};
				if (q_rx[4:0] == 5'h1F)
					next_s.rx_sense = {s.rxsh[30:0], sense_lvl};
			end
		end
		else
			next_s.div = s.div + 8'h01;
		// Write channel: address and data taken in either order
		if (awvalid && s.awready)
		begin
			next_s.aw_hold = 1'b1;
			next_s.wa = awaddr;
		end
		if (wvalid && s.wready)
		begin
			next_s.w_hold = 1'b1;
			next_s.wd = wdata;
			next_s.ws = wstrb;
		end
		if (s.aw_hold && s.w_hold && !s.bvalid)
		begin
			next_s.aw_hold = 1'b0;
			next_s.w_hold = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = tdm_pkg::RESP_OKAY;
			case (s.wa)
				tdm_pkg::REG_CTRL:
					if (s.ws[0])
					begin
						next_s.en = s.wd[tdm_pkg::CTRL_EN];
						next_s.fmt = s.wd[tdm_pkg::CTRL_FMT +: 2];
						next_s.rslot = s.wd[tdm_pkg::CTRL_SLOT +: 4];
					end
				tdm_pkg::REG_TXWORD:
					for (int i = 0; i < 4; i++)
						if (s.ws[i])
							next_s.txw[8*i +: 8] = s.wd[8*i +: 8];
				tdm_pkg::REG_RXSENSE, tdm_pkg::REG_FRAMES:
					next_s.bresp = tdm_pkg::RESP_OKAY; // Read only
				default:
					next_s.bresp = tdm_pkg::RESP_SLVERR; // Unmapped
			endcase
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		next_s.awready = ~next_s.aw_hold;
		next_s.wready = ~next_s.w_hold;
		// Read channel
		if (arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = tdm_pkg::RESP_OKAY;
			case (araddr)
				tdm_pkg::REG_CTRL:
					next_s.rdata = {25'h0000000, s.rslot, s.fmt, s.en};
				tdm_pkg::REG_TXWORD:
					next_s.rdata = s.txw;
				tdm_pkg::REG_RXSENSE:
					next_s.rdata = s.rx_sense;
				tdm_pkg::REG_FRAMES:
					next_s.rdata = {16'h0000, s.frames};
				default:
				begin
					next_s.rdata = 32'h00000000;
					next_s.rresp = tdm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		next_s.arready = ~next_s.rvalid;
	end

	// Register state
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign link.bclk = s.bclk;
	assign link.fsync = s.fsync;
	assign link.sdata = s.sdata;
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
endmodule

// *** verilog/tdm_pkg.sv ***
// Shared constants for the serial audio link and its current-sense return.
// Assumes a 200 MHz system clock on both ends of the link.
package tdm_pkg;
	// ==========================================================
	// Formats and rates
	localparam logic [1:0] FMT_I2S = 2'h0; // Two channels, 64 bits
	localparam logic [1:0] FMT_TDM4 = 2'h1; // Four slots
	localparam logic [1:0] FMT_TDM8 = 2'h2; // Eight slots
	localparam logic [1:0] FMT_TDM16 = 2'h3; // Sixteen slots
	localparam logic [1:0] RATE_44K1 = 2'h0; // 44.1 kHz
	localparam logic [1:0] RATE_48K = 2'h1; // 48 kHz
	localparam logic [1:0] RATE_96K = 2'h2; // 96 kHz
	localparam logic [1:0] RATE_192K = 2'h3; // 192 kHz
	// ==========================================================
	// Frame geometry
	localparam logic [9:0] I2S_FRAME_BITS = 10'h040; // 64 bit clocks
	localparam logic [9:0] POS_MAX = 10'h3FF; // Position counter ceiling
	localparam logic [9:0] I2S_HALF_BITS = 10'h020; // Word select high span
	// ==========================================================
	// Current sense
	localparam logic [2:0] SENSE_MODE_ON = 3'h3; // Monitoring enabled
	localparam logic [4:0] K_OSR0 = 5'h07; // 437.5 mFs in sixteenths
	localparam logic [4:0] K_OSR1 = 5'h08; // 500 mFs
	localparam logic [4:0] K_OSR2 = 5'h09; // 562.5 mFs
	localparam logic [4:0] K_96K = 5'h04; // 250 mFs
	localparam logic [4:0] K_192K = 5'h02; // 125 mFs
	// ==========================================================
	// Timing
	localparam int CLK_NS = 5; // System clock period
	localparam int LOSS_NS = 1000; // Bit clock silence before standby
	localparam int LOSS_CYC = (LOSS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WDOG_44K1_US = 2900; // Watchdog at 44.1 kHz
	localparam int WDOG_OTHER_US = 2700; // Watchdog at other rates
	localparam int WDOG_44K1_CYC = WDOG_44K1_US * 1000 / CLK_NS;
	localparam int WDOG_OTHER_CYC = WDOG_OTHER_US * 1000 / CLK_NS;
	localparam int HOST_HALF_CYC = 8; // Host bit clock half period
	// ==========================================================
	// Status flag positions
	localparam int STAT_CFG = 0; // Unsupported format and rate
	localparam int STAT_FERR = 1; // Frame length error
	localparam int STAT_WDOG = 2; // Watchdog timeout
	// ==========================================================
	// Host register map
	localparam logic [7:0] REG_CTRL = 8'h00; // Enable, format, slot
	localparam logic [7:0] REG_TXWORD = 8'h04; // Transmit word
	localparam logic [7:0] REG_RXSENSE = 8'h08; // Last sense word
	localparam logic [7:0] REG_FRAMES = 8'h0C; // Frame counter
	localparam int CTRL_EN = 0; // Link enable bit
	localparam int CTRL_FMT = 1; // Format field low bit
	localparam int CTRL_SLOT = 3; // Sense slot field low bit
	localparam logic [1:0] RESP_OKAY = 2'h0; // AXI OKAY
	localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR
endpackage

// *** verilog/tdm_link_if.sv ***
// Serial audio link between the audio host and the amplifier input.
// The bench resolves nothing: all four lines are one-way.
`timescale 1ns/1ps
interface tdm_link_if;
	logic bclk; // Serial bit clock, host to device
	logic fsync; // Frame sync, host to device
	logic sdata; // Audio data, host to device
	logic sense; // Current-sense data, device to host
	modport host (output bclk, output fsync, output sdata, input sense);
	modport device (input bclk, input fsync, input sdata, output sense);
endinterface

// *** verilog/edge_sync.sv ***
// Two-flop synchroniser with edge detection on the settled copy.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ps
module edge_sync #(
	parameter int W = 1 // Number of lines
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [W-1:0] async_in, // Raw pins
	output logic [W-1:0] level, // Settled level
	output logic [W-1:0] rise, // One-cycle rising pulse
	output logic [W-1:0] fall // One-cycle falling pulse
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [W-1:0] meta; // First stage, read by second only
		logic [W-1:0] stable; // Second stage
		logic [W-1:0] prev; // Delayed copy for edges
	} sync_t;
	sync_t s; // Current state
	sync_t next_s; // Next state

	// Shift the chain
	always_comb
	begin
		next_s.meta = async_in;
		next_s.stable = s.meta;
		next_s.prev = s.stable;
	end

	// Register the chain
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign level = s.stable;
	assign rise = s.stable & ~s.prev;
	assign fall = ~s.stable & s.prev;
endmodule

// *** verilog/tdm_sense_device.sv ***
// Amplifier end: serial audio receiver, frame check, watchdog, clock
// loss detection and the current-sense return stream.
// Assumes config inputs and currents are in the clk domain; link pins
// are asynchronous and are synchronised here.
`timescale 1ns/1ps
module tdm_sense_device #(
	parameter int WDOG_44K1_CYC = tdm_pkg::WDOG_44K1_CYC, // Timeout
	parameter int WDOG_OTHER_CYC = tdm_pkg::WDOG_OTHER_CYC, // Timeout
	parameter int LOSS_CYC = tdm_pkg::LOSS_CYC // Clock loss window
) (
	input wire logic clk, // System clock, 200 MHz
	input wire logic rst_n, // Synchronous reset, active low
	tdm_link_if.device link, // Serial link pins
	input wire logic [1:0] format_sel, // Format field
	input wire logic [3:0] slot_sel, // Slot select field
	input wire logic [1:0] rate_sel, // Rate field
	input wire logic [1:0] osr_sel, // Oversampling field
	input wire logic edge_sel, // Sense launch: 1 rising, 0 falling
	input wire logic [2:0] sense_mode, // Sense mode field
	input wire logic [1:0] sense_fs, // Sense full scale field
	input wire logic wdog_en, // Watchdog enable
	input wire logic amp_active, // Amplifier in mute or play
	input wire logic signed [15:0] positive_output_current, // Code
	input wire logic signed [15:0] negative_output_current, // Code
	input wire logic clr_frame_err, // Clear frame error flag
	input wire logic clr_wdog, // Clear watchdog flag
	output logic [23:0] audio, // Selected channel sample
	output logic audio_valid, // One-cycle sample strobe
	output logic [2:0] serial_status_flags, // Watchdog and frame error flags sticky, config flag live
	output logic wdog_mute, // Watchdog mute request
	output logic standby // Bit clock lost
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [9:0] pos; // Bit clocks since frame sync edge
		logic framed; // At least one frame start seen
		logic ws_prev; // Frame sync at last bit clock
		logic [31:0] shreg; // Incoming bits
		logic [23:0] audio; // Output sample
		logic audio_valid; // Output strobe
		logic [14:0] sense_word; // Sense word of this frame
		logic pending; // Next sense bit
		logic sense; // Sense pin
		logic ferr; // Frame error flag
		logic wflag; // Watchdog flag
		logic wmute; // Watchdog mute
		logic [19:0] wcnt; // Watchdog timer
		logic [7:0] lcnt; // Clock loss timer
		logic standby; // Standby request
		logic cfg_bad; // Unsupported configuration
	} dev_t;
	dev_t s; // Current state
	dev_t next_s; // Next state

	logic [2:0] pin_lvl; // Settled {sdata, fsync, bclk}
	logic [2:0] pin_rise; // Rising pulses
	logic [2:0] pin_fall; // Falling pulses
	logic [9:0] fbits; // Bit clocks per frame
	logic [3:0] last_slot; // Highest slot of the format
	logic unsupported; // Format too long for the rate
	logic [19:0] wlimit; // Watchdog terminal count
	logic signed [16:0] diff; // Positive minus negative
	logic signed [15:0] half; // Differential load current
	logic signed [18:0] shifted; // After full-scale gain
	logic signed [15:0] clamp; // Saturated to 16 bits
	logic [4:0] k; // Fraction of full scale, sixteenths
	logic signed [20:0] prod; // Scaled code
	logic [14:0] sense_value; // Word to send, or zero
	logic [9:0] p; // Position after this bit clock
	logic ws_edge; // Frame start on this bit clock
	logic [3:0] done_slot; // Slot whose last bit just arrived
	logic [31:0] word32; // Sense slot image
	logic ferr_set; // Frame error event
	logic wflag_set; // Watchdog event

	// ==========================================================
	// Pin synchronisers
	edge_sync #(.W(3)) pins (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({link.sdata, link.fsync, link.bclk}),
		.level(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// ==========================================================
	// Format decode
	// Frame length doubles with each format step
	assign fbits = tdm_pkg::I2S_FRAME_BITS << format_sel;
	assign last_slot = 4'(fbits[9:5] - 5'h01);
	// Long formats cannot carry their slot count at high rates
	assign unsupported = (format_sel == tdm_pkg::FMT_TDM8 &&
		rate_sel == tdm_pkg::RATE_192K) ||
		(format_sel == tdm_pkg::FMT_TDM16 &&
		rate_sel[1]);
	assign wlimit = (rate_sel == tdm_pkg::RATE_44K1) ?
		20'(WDOG_44K1_CYC - 1) : 20'(WDOG_OTHER_CYC - 1);

	// ==========================================================
	// Sense word arithmetic
	assign diff = 17'(positive_output_current) -
		17'(negative_output_current);
	assign half = diff[16:1];
	// Each step of the field halves full scale; large codes saturate
	assign shifted = 19'(half) <<< sense_fs;
	assign clamp = (shifted[18:15] == {4{shifted[18]}}) ?
		shifted[15:0] : (shifted[18] ? 16'h8000 : 16'h7FFF);
	assign k = (rate_sel == tdm_pkg::RATE_192K) ? tdm_pkg::K_192K :
		(rate_sel == tdm_pkg::RATE_96K) ? tdm_pkg::K_96K :
		(osr_sel == 2'h0) ? tdm_pkg::K_OSR0 :
		(osr_sel == 2'h2) ? tdm_pkg::K_OSR2 : tdm_pkg::K_OSR1;
	assign prod = 21'(clamp) * 21'(signed'({1'b0, k}));
	assign sense_value = (sense_mode == tdm_pkg::SENSE_MODE_ON &&
		amp_active) ? prod[19:5] : 15'h0000;

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_s = s;
		p = s.pos;
		ws_edge = 1'b0;
		done_slot = 4'h0;
		word32 = 32'h00000000;
		ferr_set = 1'b0;
		wflag_set = 1'b0;
		next_s.audio_valid = 1'b0;
		next_s.cfg_bad = unsupported;
		// Clock loss: stands in for the PLL dropping lock
		if (pin_rise[0])
		begin
			next_s.lcnt = 8'h00;
			next_s.standby = 1'b0;
		end
		else if (s.lcnt == 8'(LOSS_CYC - 1))
			next_s.standby = 1'b1;
		else
			next_s.lcnt = s.lcnt + 8'h01;
		// Bit engine, one step per bit clock rise
		if (pin_rise[0])
		begin
			ws_edge = pin_lvl[1] & ~s.ws_prev;
			next_s.ws_prev = pin_lvl[1];
			next_s.shreg = {s.shreg[30:0], pin_lvl[2]};
			if (ws_edge)
			begin
				// First frame has no predecessor to measure
				if (s.framed && s.pos != fbits - 10'h001)
					ferr_set = 1'b1;
				p = 10'h000;
				next_s.framed = 1'b1;
				next_s.sense_word = sense_value;
			end
			else if (s.pos != tdm_pkg::POS_MAX)
				p = s.pos + 10'h001; // Saturate if sync vanishes
			next_s.pos = p;
			// The last bit of the final slot lands on the sync edge
			done_slot = (p[8:5] == 4'h0) ? last_slot :
				p[8:5] - 4'h1;
			if (s.framed && p[4:0] == 5'h00 && p < fbits &&
				done_slot == slot_sel && !s.cfg_bad && !s.standby)
			begin
				next_s.audio = next_s.shreg[31:8];
				next_s.audio_valid = 1'b1;
			end
			word32 = {next_s.sense_word, 17'h00000};
			// Bit for the next position, in the selected slot only
			next_s.pending = (p < fbits && p[8:5] == slot_sel) ?
				word32[~p[4:0]] : 1'b0;
			if (edge_sel)
				next_s.sense = next_s.pending;
		end
		else if (pin_fall[0] && !edge_sel)
			next_s.sense = s.pending;
		// Watchdog restarts on any frame sync rise
		if (!wdog_en)
		begin
			next_s.wcnt = 20'h00000;
			next_s.wmute = 1'b0;
		end
		else if (pin_rise[1])
		begin
			next_s.wcnt = 20'h00000;
			next_s.wmute = 1'b0;
		end
		else if (s.wcnt == wlimit)
		begin
			next_s.wmute = 1'b1;
			wflag_set = !s.wmute;
		end
		else
			next_s.wcnt = s.wcnt + 20'h00001;
		// Sticky flags: a new event beats a clear in the same cycle
		next_s.ferr = (s.ferr & ~clr_frame_err) | ferr_set;
		next_s.wflag = (s.wflag & ~clr_wdog) | wflag_set;
	end

	// Register state; standby holds until a bit clock proves itself
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.standby <= 1'b1;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign audio = s.audio;
	assign audio_valid = s.audio_valid;
	assign serial_status_flags = {s.wflag, s.ferr, s.cfg_bad};
	assign wdog_mute = s.wmute;
	assign standby = s.standby;
	assign link.sense = s.sense;
endmodule

// *** sim/tdm_link_chk.sv ***
// Wire checks on the serial link between host and device.
// Assumes clk samples the one-way link lines; instantiated, not bound.
`timescale 1ns/1ps
module tdm_link_chk (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic bclk, // Bit clock
	input wire logic fsync, // Frame sync
	input wire logic sdata, // Audio data
	input wire logic sense // Current-sense data
);
	// ==========================================================
	// Bit clock rises seen while frame sync is high
	logic [5:0] hi_cnt; // Saturates, only 1 and 32 matter
	logic bclk_q; // Previous bit clock sample
	// Count restarts whenever frame sync is low
	always_ff @(posedge clk)
	begin
		bclk_q <= bclk;
		if (!rst_n || !fsync)
			hi_cnt <= 6'h00;
		else if (bclk && !bclk_q && hi_cnt != 6'h3F)
			hi_cnt <= hi_cnt + 6'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_BCLK_HIGH: assert property ($rose(bclk) |=> bclk[*7] ##1 !bclk)
		else $error("bit clock high phase wrong");
	AST_BCLK_LOW: assert property ($fell(bclk) |=> !bclk[*7])
		else $error("bit clock low phase too short");
	AST_FSYNC_LAUNCH: assert property ($changed(fsync) |-> !bclk)
		else $error("frame sync moved while bit clock high");
	AST_SDATA_LAUNCH: assert property ($changed(sdata) |-> !bclk)
		else $error("data moved while bit clock high");
	AST_HOLD_RISE: assert property ($rose(bclk) |->
		##1 ($stable(fsync) && $stable(sdata))[*3])
		else $error("lines not held after bit clock rise");
	AST_FSYNC_SPAN: assert property ($fell(fsync) |->
		hi_cnt == 6'h01 || hi_cnt == 6'h20)
		else $error("frame sync high span wrong");
	AST_SENSE_SETUP: assert property ($rose(bclk) |-> $stable(sense))
		else $error("sense changed at host sample edge");
	AST_SENSE_EDGE: assert property ($changed(sense) |->
		bclk != $past(bclk, 7))
		else $error("sense changed away from a bit clock edge");
endmodule

// *** sim/testbench.sv ***
// Self-checking bench: host and device joined by the link interface.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] TX = 32'hA5C3_F0E1; // Low byte is dropped
	logic clk = 1'b0; // 200 MHz
	logic rst_n = 1'b0; // Reset, active low
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, av, mute, stby;
	logic [1:0] bresp, rresp, fmt = 2'h0, rate = 2'h1;
	logic [1:0] osr = 2'h1, fs = 2'h0;
	logic [3:0] slot = 4'h0;
	logic [2:0] mode = 3'h0, flags;
	logic edge_sel = 1'b1, wdog_en = 1'b0, amp = 1'b1;
	logic clr_fe = 1'b0, clr_wd = 1'b0;
	logic signed [15:0] pos = 16'sh2000, neg = 16'sh0000;
	logic [23:0] audio;
	int err_count = 0, total_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	tdm_link_if u_tdm_link_if ();
	tdm_audio_host #(.HALF_CYC(8)) u_tdm_audio_host (.clk(clk),
		.rst_n(rst_n), .link(u_tdm_link_if), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));
	// Short watchdog and loss windows keep the run brief
	tdm_sense_device #(.WDOG_44K1_CYC(2000), .WDOG_OTHER_CYC(1800),
		.LOSS_CYC(50)) u_tdm_sense_device (.clk(clk), .rst_n(rst_n),
		.link(u_tdm_link_if), .format_sel(fmt), .slot_sel(slot),
		.rate_sel(rate), .osr_sel(osr), .edge_sel(edge_sel),
		.sense_mode(mode), .sense_fs(fs), .wdog_en(wdog_en),
		.amp_active(amp), .positive_output_current(pos),
		.negative_output_current(neg), .clr_frame_err(clr_fe),
		.clr_wdog(clr_wd), .audio(audio), .audio_valid(av),
		.serial_status_flags(flags), .wdog_mute(mute), .standby(stby));
	tdm_link_chk u_tdm_link_chk (.clk(clk), .rst_n(rst_n),
		.bclk(u_tdm_link_if.bclk), .fsync(u_tdm_link_if.fsync),
		.sdata(u_tdm_link_if.sdata), .sense(u_tdm_link_if.sense));
	// ==========================================================
	// Shared tasks
	task tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	// Address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'(r), 32'(bresp));
	endtask
	task rd(input logic [7:0] a, input logic [1:0] r);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		q = rdata;
		chk("rresp", 32'(r), 32'(rresp));
	endtask
	// Waits for n sample strobes; the timeout bounds it
	task frames(input int n);
		repeat (n)
		begin
			@(posedge clk);
			while (av !== 1'b1) @(posedge clk);
		end
	endtask
	task setup(input logic [1:0] f, input logic [3:0] s);
		fmt <= f;
		slot <= s;
		wr(tdm_pkg::REG_CTRL, {25'h0, s, f, 1'b1}, tdm_pkg::RESP_OKAY);
		frames(1);
	endtask
	// ==========================================================
	// Scenarios
	task t_format();
		for (int f = 0; f < 4; f++)
		begin
			setup(2'(f), 4'((2 << f) - 1));
			clr_fe <= 1'b1;
			@(posedge clk);
			clr_fe <= 1'b0;
			frames(1);
			chk("audio", 32'(TX[31:8]), 32'(audio));
			chk("frame_err", 0, 32'(flags[1]));
		end
	endtask
	task t_cfg();
		fmt <= tdm_pkg::FMT_TDM16;
		rate <= tdm_pkg::RATE_192K;
		repeat (4) @(posedge clk);
		chk("cfg_err", 1, 32'(flags[0]));
		fmt <= tdm_pkg::FMT_TDM8;
		rate <= tdm_pkg::RATE_96K;
		repeat (4) @(posedge clk);
		chk("cfg_err", 0, 32'(flags[0]));
		for (int i = 0; i < 20000 && flags[1] !== 1'b1; i++) @(posedge clk);
		chk("frame_err", 1, 32'(flags[1]));
		rate <= tdm_pkg::RATE_48K;
	endtask
	task t_sense();
		setup(tdm_pkg::FMT_TDM4, 4'h2);
		frames(2);
		rd(tdm_pkg::REG_RXSENSE, tdm_pkg::RESP_OKAY);
		chk("sense_off", 0, q);
		mode <= tdm_pkg::SENSE_MODE_ON;
		edge_sel <= 1'b0;
		frames(2);
		rd(tdm_pkg::REG_RXSENSE, tdm_pkg::RESP_OKAY);
		chk("sense_low", 0, {15'h0, q[16:0]});
		chk("sense_pos", 32'h0800_0000, q);
		pos <= 16'sh0000;
		neg <= 16'sh4000;
		edge_sel <= 1'b1;
		frames(2);
		rd(tdm_pkg::REG_RXSENSE, tdm_pkg::RESP_OKAY);
		chk("sense_neg", 32'hF000_0000, q);
		// Quarter full scale at 96 kHz: four times the code, half the gain
		fs <= 2'h2;
		rate <= tdm_pkg::RATE_96K;
		frames(2);
		rd(tdm_pkg::REG_RXSENSE, tdm_pkg::RESP_OKAY);
		chk("sense_scale", 32'hE000_0000, q);
		fs <= 2'h0;
		rate <= tdm_pkg::RATE_48K;
		amp <= 1'b0;
		frames(2);
		rd(tdm_pkg::REG_RXSENSE, tdm_pkg::RESP_OKAY);
		chk("sense_idle", 0, q);
		amp <= 1'b1;
		wr(tdm_pkg::REG_CTRL, 32'h0000_001B, tdm_pkg::RESP_OKAY);
		frames(2);
		rd(tdm_pkg::REG_RXSENSE, tdm_pkg::RESP_OKAY);
		chk("sense_slot", 0, q);
	endtask
	// Link stops in a low bit clock phase so no half-bit is cut
	task t_loss();
		wdog_en <= 1'b1;
		setup(tdm_pkg::FMT_I2S, 4'h0);
		clr_wd <= 1'b1;
		@(posedge clk);
		clr_wd <= 1'b0;
		frames(2);
		chk("wdog_mute", 0, 32'(mute));
		@(negedge u_tdm_link_if.bclk);
		wr(tdm_pkg::REG_CTRL, 32'h0000_0000, tdm_pkg::RESP_OKAY);
		repeat (100) @(posedge clk);
		chk("standby", 1, 32'(stby));
		repeat (2000) @(posedge clk);
		chk("wdog_mute", 1, 32'(mute));
		chk("wdog_flag", 1, 32'(flags[2]));
		wr(tdm_pkg::REG_CTRL, 32'h0000_0001, tdm_pkg::RESP_OKAY);
		frames(1);
		chk("wdog_mute", 0, 32'(mute));
		chk("standby", 0, 32'(stby));
	endtask
	// Hang guard, reckoned from the longest frame sequence
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wr(8'h10, 32'h0000_0000, tdm_pkg::RESP_SLVERR);
		rd(8'h10, tdm_pkg::RESP_SLVERR);
		wr(tdm_pkg::REG_TXWORD, TX, tdm_pkg::RESP_OKAY);
		t_format();
		t_cfg();
		t_sense();
		t_loss();
		tally_and_finish();
	end
endmodule
